// ==== rtl/gsl_regs.vh ====
`ifndef GSL_REGS_VH
`define GSL_REGS_VH

// port geometry
`define GSL_NPIN        32
`define GSL_IDX_W       5
`define GSL_WORD_W      32

// per-pin configuration word layout
`define GSL_DIR_BIT     0
`define GSL_DISC_BIT    1
`define GSL_PULL_LO     2
`define GSL_PULL_HI     3
`define GSL_DRV_LO      8
`define GSL_DRV_HI      10
`define GSL_SNS_LO      16
`define GSL_SNS_HI      17
`define GSL_CFG_RST     32'h0000_0002
`define GSL_CFG_MASK    32'h0003_070f

// pull encodings
`define GSL_PULL_DOWN   2'h1
`define GSL_PULL_UP     2'h3

// drive encodings: bit 2 marks a disconnected level, bit 1 picks it, bit 0 the other level's drive
`define GSL_DRV_S0S1    3'h0
`define GSL_DRV_H0S1    3'h1
`define GSL_DRV_S0H1    3'h2
`define GSL_DRV_H0H1    3'h3
`define GSL_DRV_D0S1    3'h4
`define GSL_DRV_D0H1    3'h5
`define GSL_DRV_S0D1    3'h6
`define GSL_DRV_H0D1    3'h7

// level-watch encodings
`define GSL_SNS_OFF     2'h0
`define GSL_SNS_HIGH    2'h2
`define GSL_SNS_LOW     2'h3

// match source select
`define GSL_SRC_COMB    1'h0
`define GSL_SRC_HELD    1'h1

// pins that also carry an analog function
`define GSL_ANA_MASK    32'h0000_0000

`define GSL_ZERO32      32'h0000_0000
`define GSL_ONES32      32'hffff_ffff

`endif

// ==== rtl/gsl_cfg_mem.v ====
`timescale 1ns/1ps
`include "gsl_regs.vh"

// per-pin configuration words, readback side
module gsl_cfg_mem (
  input  wire                     clk_in,
  input  wire                     srst_in,
  input  wire                     wr_in,
  input  wire [`GSL_IDX_W-1:0]    wr_idx_in,
  input  wire [`GSL_WORD_W-1:0]   wr_data_in,
  input  wire [`GSL_IDX_W-1:0]    rd_idx_in,
  output reg  [`GSL_WORD_W-1:0]   rd_data_out
);

  reg [`GSL_WORD_W-1:0] mem_r [0:`GSL_NPIN-1];
  integer               i;

  always @(posedge clk_in) begin
    if (srst_in) begin
      for (i = 0; i < `GSL_NPIN; i = i + 1) begin
        mem_r[i] <= `GSL_CFG_RST;
      end
      rd_data_out <= `GSL_CFG_RST;
    end else begin
      if (wr_in) begin
        mem_r[wr_idx_in] <= wr_data_in & `GSL_CFG_MASK;
      end
      rd_data_out <= mem_r[rd_idx_in];
    end
  end

endmodule

// ==== rtl/gsl_port.v ====
`timescale 1ns/1ps
`include "gsl_regs.vh"

// What this block does
// - Up to 32 pins, each set up by its own configuration word.
// - Each pin's level-watch picks a high or a low input level.
// - Level-watch code: 0 off, 2 watch high, 3 watch low.
// - A watched pin at its level raises its own match signal.
// - Default source ORs all pin matches into one port-wide match.
// - Watch and match logic keep running in system off too.
// - Match rises at once if the condition already holds on enable.
// - Port-wide match rising makes the task/event unit's port event.
// - Port-wide match goes to the power unit as wake source.
// - A rising pin match sets capture bit of the same number.
// - Clearing a capture bit is ignored while its pin still matches.
// - Capture bits clear only on a written one, never by match falling.
// - Held match is high while any capture bit is set, except in the cycle after a clear.
// - A clear that leaves bits set gives held match a new rising edge.
// - Capture bits readable any time, in either source mode.
// - Port-wide match comes from held match only when selected.
// - Source select: 0 combined pin matches, 1 held match.
// - Disconnected input buffer gives no input value and no watching.
// - Other units may override output and direction and read inputs.
// - Config holds direction, drive, pulls, watch and disconnect.
// - Configuration words are retained across low-power states.
module gsl_port (
  input  wire                     clk_in,
  input  wire                     srst_in,
  // pad side
  input  wire [`GSL_NPIN-1:0]     pin_in,
  output reg  [`GSL_NPIN-1:0]     pin_out_out,
  output reg  [`GSL_NPIN-1:0]     pin_oe_out,
  output reg  [`GSL_NPIN-1:0]     pull_up_out,
  output reg  [`GSL_NPIN-1:0]     pull_down_out,
  output reg  [`GSL_NPIN-1:0]     high_drive_out,
  output reg  [`GSL_NPIN-1:0]     analog_pin_input_out,
  // cpu side: output and direction
  input  wire                     out_wr_in,
  input  wire                     out_set_in,
  input  wire                     out_clr_in,
  input  wire [`GSL_NPIN-1:0]     out_wdata_in,
  output wire [`GSL_NPIN-1:0]     out_rdata_out,
  input  wire                     dir_wr_in,
  input  wire                     dir_set_in,
  input  wire                     dir_clr_in,
  input  wire [`GSL_NPIN-1:0]     dir_wdata_in,
  output wire [`GSL_NPIN-1:0]     dir_rdata_out,
  output reg  [`GSL_NPIN-1:0]     in_rdata_out,
  // cpu side: pin_config words
  input  wire                     cfg_wr_in,
  input  wire [`GSL_IDX_W-1:0]    cfg_idx_in,
  input  wire [`GSL_WORD_W-1:0]   cfg_wdata_in,
  input  wire [`GSL_IDX_W-1:0]    cfg_rd_idx_in,
  output wire [`GSL_WORD_W-1:0]   cfg_rdata_out,
  // cpu side: capture flags and source select
  input  wire                     latch_clr_in,
  input  wire [`GSL_NPIN-1:0]     latch_wdata_in,
  output wire [`GSL_NPIN-1:0]     latch_out,
  input  wire                     match_source_select_in,
  // other units
  input  wire [`GSL_NPIN-1:0]     ovr_en_in,
  input  wire [`GSL_NPIN-1:0]     ovr_out_in,
  input  wire [`GSL_NPIN-1:0]     ovr_dir_in,
  output wire [`GSL_NPIN-1:0]     unit_in_out,
  output wire [`GSL_NPIN-1:0]     pin_level_match_out,
  output wire                     held_match_signal_out,
  output wire                     port_match_out,
  output wire                     wake_out,
  output wire                     port_event_out
);

  reg  [`GSL_NPIN-1:0]   out_r;
  reg  [`GSL_NPIN-1:0]   out_nxt;
  reg  [`GSL_NPIN-1:0]   dir_r;
  reg  [`GSL_NPIN-1:0]   dir_nxt;
  reg  [`GSL_NPIN-1:0]   disc_r;
  reg  [2*`GSL_NPIN-1:0] pull_r;
  reg  [3*`GSL_NPIN-1:0] drv_r;
  reg  [2*`GSL_NPIN-1:0] sns_r;
  reg  [`GSL_NPIN-1:0]   match;
  reg  [`GSL_NPIN-1:0]   match_d_r;
  reg  [`GSL_NPIN-1:0]   latch_r;
  reg  [`GSL_NPIN-1:0]   latch_nxt;
  reg                    held_r;
  reg                    held_nxt;
  reg                    port_r;
  reg                    port_d_r;
  reg                    ev_r;
  reg  [`GSL_NPIN-1:0]   eff_out;
  reg  [`GSL_NPIN-1:0]   eff_dir;
  reg  [`GSL_NPIN-1:0]   conn_in;
  reg  [`GSL_NPIN-1:0]   oe_nxt;
  reg  [`GSL_NPIN-1:0]   hd_nxt;
  reg  [`GSL_NPIN-1:0]   pu_nxt;
  reg  [`GSL_NPIN-1:0]   pd_nxt;
  reg  [2:0]             drv_f;
  reg  [1:0]             sns_f;
  reg  [1:0]             pull_f;
  integer                p;

  // level-watch decode for one pin
  function pin_watch;
    input [1:0] sense;
    input       level;
    input       connected;
    begin
      case (sense)
        `GSL_SNS_HIGH: pin_watch = connected & level;
        `GSL_SNS_LOW:  pin_watch = connected & ~level;
        default:       pin_watch = 1'b0;
      endcase
    end
  endfunction

  // pad drive enable for one pin given the drive code
  function pin_drives;
    input [2:0] drive;
    input       dir;
    input       level;
    begin
      case (drive)
        `GSL_DRV_D0S1, `GSL_DRV_D0H1: pin_drives = dir & level;
        `GSL_DRV_S0D1, `GSL_DRV_H0D1: pin_drives = dir & ~level;
        default:                      pin_drives = dir;
      endcase
    end
  endfunction

  // high drive for the level being driven
  function pin_strong;
    input [2:0] drive;
    input       level;
    begin
      case (drive)
        `GSL_DRV_H0S1, `GSL_DRV_H0D1: pin_strong = ~level;
        `GSL_DRV_S0H1, `GSL_DRV_D0H1: pin_strong = level;
        `GSL_DRV_H0H1:                pin_strong = 1'b1;
        default:                      pin_strong = 1'b0;
      endcase
    end
  endfunction

  gsl_cfg_mem u_cfg (
    .clk_in      (clk_in),
    .srst_in     (srst_in),
    .wr_in       (cfg_wr_in),
    .wr_idx_in   (cfg_idx_in),
    .wr_data_in  (cfg_wdata_in),
    .rd_idx_in   (cfg_rd_idx_in),
    .rd_data_out (cfg_rdata_out)
  );

  // decoded copy of the fields the logic needs for all pins at once;
  // only srst_in resets them, no low-power signal reaches here
  always @(posedge clk_in) begin
    if (srst_in) begin
      disc_r <= `GSL_ONES32;
      pull_r <= {2*`GSL_NPIN{1'b0}};
      drv_r  <= {3*`GSL_NPIN{1'b0}};
      sns_r  <= {2*`GSL_NPIN{1'b0}};
    end else if (cfg_wr_in) begin
      disc_r[cfg_idx_in]     <= cfg_wdata_in[`GSL_DISC_BIT];
      pull_r[2*cfg_idx_in+:2] <= cfg_wdata_in[`GSL_PULL_HI:`GSL_PULL_LO];
      drv_r[3*cfg_idx_in+:3]  <= cfg_wdata_in[`GSL_DRV_HI:`GSL_DRV_LO];
      sns_r[2*cfg_idx_in+:2]  <= cfg_wdata_in[`GSL_SNS_HI:`GSL_SNS_LO];
    end
  end

  // output and direction, with write, set-ones and clear-ones forms;
  // a config write also carries the direction bit
  always @* begin
    out_nxt = out_r;
    if (out_wr_in) begin
      out_nxt = out_wdata_in;
    end
    if (out_set_in) begin
      out_nxt = out_nxt | out_wdata_in;
    end
    if (out_clr_in) begin
      out_nxt = out_nxt & ~out_wdata_in;
    end
    dir_nxt = dir_r;
    if (dir_wr_in) begin
      dir_nxt = dir_wdata_in;
    end
    if (dir_set_in) begin
      dir_nxt = dir_nxt | dir_wdata_in;
    end
    if (dir_clr_in) begin
      dir_nxt = dir_nxt & ~dir_wdata_in;
    end
    if (cfg_wr_in) begin
      dir_nxt[cfg_idx_in] = cfg_wdata_in[`GSL_DIR_BIT];
    end
  end

  always @(posedge clk_in) begin
    if (srst_in) begin
      out_r <= `GSL_ZERO32;
      dir_r <= `GSL_ZERO32;
    end else begin
      out_r <= out_nxt;
      dir_r <= dir_nxt;
    end
  end

  assign out_rdata_out = out_r;
  assign dir_rdata_out = dir_r;

  // per-pin combinational view: override, input gating, watch
  always @* begin
    eff_out = (out_r & ~ovr_en_in) | (ovr_out_in & ovr_en_in);
    eff_dir = (dir_r & ~ovr_en_in) | (ovr_dir_in & ovr_en_in);
    conn_in = pin_in & ~disc_r;
    match   = `GSL_ZERO32;
    oe_nxt  = `GSL_ZERO32;
    hd_nxt  = `GSL_ZERO32;
    pu_nxt  = `GSL_ZERO32;
    pd_nxt  = `GSL_ZERO32;
    sns_f   = 2'h0;
    drv_f   = 3'h0;
    pull_f  = 2'h0;
    for (p = 0; p < `GSL_NPIN; p = p + 1) begin
      sns_f    = sns_r[2*p+:2];
      drv_f    = drv_r[3*p+:3];
      pull_f   = pull_r[2*p+:2];
      // no clock gating here: matches stay live in system off
      match[p] = pin_watch(sns_f, pin_in[p], ~disc_r[p]);
      oe_nxt[p] = pin_drives(drv_f, eff_dir[p], eff_out[p]);
      hd_nxt[p] = pin_strong(drv_f, eff_out[p]);
      pu_nxt[p] = (pull_f == `GSL_PULL_UP);
      pd_nxt[p] = (pull_f == `GSL_PULL_DOWN);
    end
  end

  assign unit_in_out         = conn_in;
  assign pin_level_match_out = match;

  // pad controls come from flops
  always @(posedge clk_in) begin
    if (srst_in) begin
      pin_out_out          <= `GSL_ZERO32;
      pin_oe_out           <= `GSL_ZERO32;
      pull_up_out          <= `GSL_ZERO32;
      pull_down_out        <= `GSL_ZERO32;
      high_drive_out       <= `GSL_ZERO32;
      analog_pin_input_out <= `GSL_ZERO32;
      in_rdata_out         <= `GSL_ZERO32;
    end else begin
      pin_oe_out           <= oe_nxt;
      high_drive_out       <= hd_nxt;
      pull_up_out          <= pu_nxt;
      pull_down_out        <= pd_nxt;
      pin_out_out          <= eff_out;
      // analog path only where the pad has one and the buffer is off
      analog_pin_input_out <= `GSL_ANA_MASK & disc_r;
      in_rdata_out         <= conn_in;
    end
  end

  // capture flags: rising match sets, written ones clear unless the
  // pin still matches; set wins over clear in the same cycle
  always @* begin
    latch_nxt = latch_r;
    if (latch_clr_in) begin
      latch_nxt = latch_nxt & ~(latch_wdata_in & ~match);
    end
    latch_nxt = latch_nxt | (match & ~match_d_r);
    // any clear drops held for one cycle, so flags left set, or set
    // in the clear cycle itself, always show a fresh rising edge
    held_nxt = (|latch_nxt) & ~latch_clr_in;
  end

  always @(posedge clk_in) begin
    if (srst_in) begin
      match_d_r <= `GSL_ZERO32;
      latch_r   <= `GSL_ZERO32;
      held_r    <= 1'b0;
    end else begin
      match_d_r <= match;
      latch_r   <= latch_nxt;
      held_r    <= held_nxt;
    end
  end

  assign latch_out             = latch_r;
  assign held_match_signal_out = held_r;

  // port-wide match and the port event on its rising edge
  always @(posedge clk_in) begin
    if (srst_in) begin
      port_r   <= 1'b0;
      port_d_r <= 1'b0;
      ev_r     <= 1'b0;
    end else begin
      if (match_source_select_in == `GSL_SRC_HELD) begin
        port_r <= held_nxt;
      end else begin
        port_r <= |match;
      end
      port_d_r <= port_r;
      ev_r     <= port_r & ~port_d_r;
    end
  end

  assign port_match_out = port_r;
  assign wake_out       = port_r;
  assign port_event_out = ev_r;

endmodule

// ==== verif/gsl_pad_model.sv ====
`timescale 1ns/1ps
`include "gsl_regs.vh"
// board circuits on the pads: the port's own driver wins, then the
// outside driver, then the pulls
module gsl_pad_model (
  input  wire                 clk_in,
  input  wire [`GSL_NPIN-1:0] pin_out_in,
  input  wire [`GSL_NPIN-1:0] pin_oe_in,
  input  wire [`GSL_NPIN-1:0] pull_up_in,
  input  wire [`GSL_NPIN-1:0] pull_down_in,
  input  wire [`GSL_NPIN-1:0] ext_en_in,
  input  wire [`GSL_NPIN-1:0] ext_val_in,
  output wire [`GSL_NPIN-1:0] level_out
);
  reg [`GSL_NPIN-1:0] float_r = `GSL_ZERO32;
  // a pad nobody holds wanders, so no test can lean on a stale level
  always @(posedge clk_in) begin
    float_r <= ~float_r;
  end
  assign level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_en_in & ext_val_in)
    | (~pin_oe_in & ~ext_en_in & (pull_up_in | (~pull_down_in & float_r)));
endmodule

// ==== verif/gsl_port_monitor.sv ====
`timescale 1ns/1ps
`include "gsl_regs.vh"
module gsl_port_monitor (
  input wire                 clk_in,
  input wire                 srst_in,
  input wire                 latch_clr_in,
  input wire [`GSL_NPIN-1:0] latch_wdata_in,
  input wire [`GSL_NPIN-1:0] latch_out,
  input wire                 match_source_select_in,
  input wire [`GSL_NPIN-1:0] pin_level_match_out,
  input wire                 held_match_signal_out,
  input wire                 port_match_out,
  input wire                 wake_out,
  input wire                 port_event_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence s_clr_left;
    latch_clr_in ##1 ((|latch_out) && !latch_clr_in);
  endsequence
  sequence s_dip;
    !held_match_signal_out ##1 held_match_signal_out;
  endsequence
  property p_comb;
    !$past(match_source_select_in) |-> port_match_out == (|$past(pin_level_match_out));
  endproperty
  a_comb: assert property (p_comb) else $error("port match off pin matches");
  property p_src;
    $past(match_source_select_in) |-> port_match_out == held_match_signal_out;
  endproperty
  a_src: assert property (p_src) else $error("port match off held match");
  property p_set;
    (latch_out & $past(pin_level_match_out)) == $past(pin_level_match_out);
  endproperty
  a_set: assert property (p_set) else $error("capture flag not set");
  property p_keep;
    ($past(latch_out) & ~latch_out
      & ~($past(latch_wdata_in) & {`GSL_NPIN{$past(latch_clr_in)}})) == `GSL_ZERO32;
  endproperty
  a_keep: assert property (p_keep) else $error("capture flag lost");
  property p_held;
    !$past(latch_clr_in) |-> held_match_signal_out == (|latch_out);
  endproperty
  a_held: assert property (p_held) else $error("held match off flags");
  property p_reedge;
    s_clr_left |-> s_dip;
  endproperty
  a_reedge: assert property (p_reedge) else $error("no new held edge");
  property p_event;
    $rose(port_match_out) |=> port_event_out;
  endproperty
  a_event: assert property (p_event) else $error("port event missing");
  property p_wake;
    wake_out == port_match_out;
  endproperty
  a_wake: assert property (p_wake) else $error("wake differs");
endmodule
bind gsl_port gsl_port_monitor u_mon (
  .clk_in(clk_in), .srst_in(srst_in), .latch_clr_in(latch_clr_in),
  .latch_wdata_in(latch_wdata_in), .latch_out(latch_out),
  .match_source_select_in(match_source_select_in), .pin_level_match_out(pin_level_match_out),
  .held_match_signal_out(held_match_signal_out), .port_match_out(port_match_out),
  .wake_out(wake_out), .port_event_out(port_event_out)
);

// ==== verif/gpio_sense_latch_port_tb.sv ====
`timescale 1ns/1ps
`include "gsl_regs.vh"
module gpio_sense_latch_port_tb;
  localparam [7:0] S_OWR = 8'h01, S_OCLR = 8'h04, S_DSET = 8'h10, S_CFG = 8'h40, S_LCLR = 8'h80;
  localparam [7:0] S_OSET = 8'h02, S_DWR = 8'h08, S_DCLR = 8'h20;
  reg         clk_in, srst_in, match_source_select_in;
  reg  [7:0]  stb;
  reg  [4:0]  idx;
  reg  [31:0] wd, ext_val, ext_en, ovr_en_in, ovr_out_in, ovr_dir_in;
  wire [31:0] pin_in, pin_out_out, pin_oe_out, pull_up_out, pull_down_out, out_rdata_out;
  wire [31:0] dir_rdata_out, in_rdata_out, cfg_rdata_out, latch_out, pin_level_match_out;
  wire [31:0] high_drive_out, analog_pin_input_out, unit_in_out;
  wire        held_match_signal_out, port_match_out, wake_out, port_event_out;
  integer     err_count, checks;
  always #10 clk_in = ~clk_in;
  gsl_port dut (
    .clk_in(clk_in), .srst_in(srst_in), .pin_in(pin_in), .pin_out_out(pin_out_out),
    .pin_oe_out(pin_oe_out), .pull_up_out(pull_up_out), .pull_down_out(pull_down_out),
    .high_drive_out(high_drive_out), .analog_pin_input_out(analog_pin_input_out),
    .out_wr_in(stb[0]), .out_set_in(stb[1]),
    .out_clr_in(stb[2]), .out_wdata_in(wd), .out_rdata_out(out_rdata_out),
    .dir_wr_in(stb[3]), .dir_set_in(stb[4]), .dir_clr_in(stb[5]), .dir_wdata_in(wd),
    .dir_rdata_out(dir_rdata_out), .in_rdata_out(in_rdata_out), .cfg_wr_in(stb[6]),
    .cfg_idx_in(idx), .cfg_wdata_in(wd), .cfg_rd_idx_in(idx), .cfg_rdata_out(cfg_rdata_out),
    .latch_clr_in(stb[7]), .latch_wdata_in(wd), .latch_out(latch_out),
    .match_source_select_in(match_source_select_in), .ovr_en_in(ovr_en_in),
    .ovr_out_in(ovr_out_in), .ovr_dir_in(ovr_dir_in), .unit_in_out(unit_in_out),
    .pin_level_match_out(pin_level_match_out), .held_match_signal_out(held_match_signal_out),
    .port_match_out(port_match_out), .wake_out(wake_out), .port_event_out(port_event_out)
  );
  gsl_pad_model pads (
    .clk_in(clk_in), .pin_out_in(pin_out_out), .pin_oe_in(pin_oe_out), .pull_up_in(pull_up_out),
    .pull_down_in(pull_down_out), .ext_en_in(ext_en), .ext_val_in(ext_val),
    .level_out(pin_in)
  );
  task step(input integer n);
    begin
      repeat (n) @(posedge clk_in);
      #1;
    end
  endtask
  // one strobe cycle, then a quiet edge so strobes never merge
  task op(input [7:0] s, input [4:0] i, input [31:0] d);
    begin
      @(posedge clk_in);
      stb <= s;
      idx <= i;
      wd <= d;
      @(posedge clk_in);
      stb <= 8'h00;
      #1;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task complete_run;
    begin
      if (err_count == 0 && checks > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  initial begin
    #20000;
    err_count = err_count + 1;
    complete_run;
  end
  initial begin
    clk_in = 1'b0;
    srst_in = 1'b1;
    match_source_select_in = `GSL_SRC_COMB;
    stb = 8'h00;
    idx = 5'h00;
    wd = `GSL_ZERO32;
    ext_val = 32'h8000_0201;
    ext_en = `GSL_ONES32;
    ovr_en_in = `GSL_ZERO32;
    ovr_out_in = `GSL_ZERO32;
    ovr_dir_in = `GSL_ZERO32;
    err_count = 0;
    checks = 0;
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    step(1);
    chk(cfg_rdata_out, `GSL_CFG_RST);
    chk(latch_out, `GSL_ZERO32);
    chk(analog_pin_input_out, `GSL_ANA_MASK);
    // pin 0 already high when its watch is switched on
    op(S_CFG, 5'h00, 32'h0002_0000);
    chk(pin_level_match_out, 32'h0000_0001);
    step(1);
    chk(latch_out, 32'h0000_0001);
    chk({29'h0, port_match_out, wake_out, held_match_signal_out}, 32'h7);
    step(1);
    chk({31'h0, port_event_out}, 32'h1);
    chk(cfg_rdata_out, 32'h0002_0000);
    op(S_LCLR, 5'h00, 32'h0000_0001);
    chk(latch_out, 32'h0000_0001);
    chk({31'h0, held_match_signal_out}, 32'h0);
    step(1);
    chk({31'h0, held_match_signal_out}, 32'h1);
    // pin 31 parked high before its low watch goes on
    op(S_CFG, 5'h1f, 32'h0003_0000);
    step(1);
    chk(pin_level_match_out, 32'h0000_0001);
    @(posedge clk_in);
    ext_val <= 32'h0000_0201;
    step(3);
    chk(latch_out, 32'h8000_0001);
    @(posedge clk_in);
    ext_val <= 32'h8000_0201;
    step(3);
    chk(pin_level_match_out, 32'h0000_0001);
    chk(latch_out, 32'h8000_0001);
    op(S_LCLR, 5'h00, `GSL_ZERO32);
    chk(latch_out, 32'h8000_0001);
    op(S_LCLR, 5'h00, `GSL_ONES32);
    chk(latch_out, 32'h0000_0001);
    op(S_CFG, 5'h00, `GSL_ZERO32);
    @(posedge clk_in);
    match_source_select_in <= `GSL_SRC_HELD;
    step(2);
    chk({pin_level_match_out[0], port_match_out, latch_out[0]}, 32'h3);
    op(S_LCLR, 5'h00, 32'h0000_0001);
    step(1);
    chk(latch_out, `GSL_ZERO32);
    chk({30'h0, held_match_signal_out, port_match_out}, 32'h0);
    @(posedge clk_in);
    match_source_select_in <= `GSL_SRC_COMB;
    // pin 9 high but its input buffer cut off
    op(S_CFG, 5'h09, 32'h0002_0002);
    step(2);
    chk(pin_level_match_out, `GSL_ZERO32);
    chk(in_rdata_out & 32'h8000_0200, 32'h8000_0000);
    chk(unit_in_out & 32'h8000_0200, 32'h8000_0000);
    chk(cfg_rdata_out, 32'h0002_0002);
    op(S_OWR, 5'h00, 32'h0000_0010);
    op(S_DSET, 5'h00, 32'h0000_0010);
    chk(dir_rdata_out & out_rdata_out, 32'h0000_0010);
    @(posedge clk_in);
    ovr_en_in <= 32'h0000_0020;
    ovr_out_in <= 32'h0000_0020;
    ovr_dir_in <= 32'h0000_0020;
    step(2);
    chk(pin_oe_out & pin_out_out, 32'h0000_0030);
    op(S_OCLR, 5'h00, 32'h0000_0010);
    step(1);
    chk(pin_out_out & 32'h0000_0030, 32'h0000_0020);
    // pin 4 pulled up with wired-and drive, pin 6 pulled down
    op(S_CFG, 5'h04, 32'h0000_070d);
    op(S_CFG, 5'h06, 32'h0000_0104);
    step(1);
    chk({pull_up_out[4], pull_down_out[6], high_drive_out[4], pin_oe_out[4]}, 32'hf);
    op(S_OSET, 5'h00, 32'h0000_0010);
    @(posedge clk_in);
    ext_en <= 32'hffff_ffaf;
    step(2);
    chk({pin_oe_out[4], high_drive_out[4], pin_oe_out[5]}, 32'h1);
    chk(in_rdata_out & 32'h0000_0050, 32'h0000_0010);
    op(S_DCLR, 5'h00, 32'h0000_0010);
    op(S_DWR, 5'h00, 32'h0000_0041);
    chk(dir_rdata_out, 32'h0000_0041);
    complete_run;
  end
endmodule
